/* File: stc_defs.svh */
// Register offsets, field positions, reset values and timing constants.
// Assumes a 250 MHz ref_clk; included by the package, stc_bucket and stc_regs.
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define STC_CMD_TURN_ON_DELAY   8'h60
`define STC_CMD_RAMP_TIME       8'h61
`define STC_CMD_OT_WARN         8'h51
`define STC_MANT_W              7
`define STC_OTW_MANT_W          11
`define STC_TON_RESET           7'h00
`define STC_RISE_RESET          7'h05
`define STC_OTW_RESET           11'h064
`define STC_OTW_MIN             11'h064
`define STC_OTW_MAX             11'h08C
`define STC_MANT_LSB            0
`define STC_EXP_ZERO            5'h00
`define STC_UPPER_ZERO          4'h0
`define STC_TMAX_DISABLED       7'h00
`define STC_TINY_DELAY_NS       50
`define STC_CLK_PERIOD_NS       4
`define STC_MS_ZERO             7'h00
`define STC_MS_ONE              7'h01
`endif

/* File: stc_pkg.sv */
// Types shared by the startup timing register bank and its decoder.
// Assumes stc_defs.svh is on the include path.
`include "stc_defs.svh"
package stc_pkg;
	// One host write: command code and data word.
	typedef struct packed {
		logic        valid;
		logic [7:0]  cmd;
		logic [15:0] data;
	} stc_wr_s;
	// Host-visible rejection status.
	typedef struct packed {
		logic commFault;
		logic invalidData;
		logic alert;
	} stc_flag_s;
	typedef enum logic [1:0] {STC_IDLE, STC_CHECK, STC_DONE} stc_state_e;
endpackage

/* File: stc_bucket.sv */
// Quantises a time mantissa into one of sixteen supported millisecond times.
// Assumes a registered mantissa input; output is combinational.
`timescale 1ns/1ps
`include "stc_defs.svh"
module stc_bucket
	import stc_pkg::*;
#(
	parameter int MW = `STC_MANT_W
) (
	// Mantissa in and bucket time out.
	input  wire logic [MW-1:0] mant,
	input  wire logic          minOne,
	output logic      [MW-1:0] effMs,
	output logic               tiny
);
	// Bucket boundaries; zero is a 50 ns step unless the one ms floor applies.
	assign tiny  = (mant == `STC_MS_ZERO) && !minOne;
	assign effMs = (mant <= 7'd1)  ? (minOne ? `STC_MS_ONE : mant) :
	               (mant <= 7'd6)  ? mant :
	               (mant <= 7'd9)  ? 7'd7  :
	               (mant <= 7'd12) ? 7'd10 :
	               (mant <= 7'd17) ? 7'd14 :
	               (mant <= 7'd22) ? 7'd19 :
	               (mant <= 7'd32) ? 7'd27 :
	               (mant <= 7'd44) ? 7'd37 :
	               (mant <= 7'd62) ? 7'd52 :
	               (mant <= 7'd86) ? 7'd72 : 7'd100;
endmodule

/* File: stc_regs.sv */
// Startup timing configuration registers of a power converter.
// Assumes writes arrive decoded from the management bus command engine.
`timescale 1ns/1ps
`include "stc_defs.svh"
module stc_regs
	import stc_pkg::*;
#(
	parameter int MW = `STC_MANT_W
) (
	// Clock and reset.
	input  wire logic                      ref_clk,
	input  wire logic                      nrst,
	// Host write and read select.
	input  wire stc_wr_s                   hostWr,
	input  wire logic [7:0]                rdCmd,
	// Cross-check limit and other inputs.
	input  wire logic [MW-1:0]             rampTimeoutLimit,
	input  wire logic [`STC_OTW_MANT_W-1:0] overtempFaultThreshold,
	input  wire logic                      storeAll,
	input  wire logic                      nvmLoad,
	input  wire logic [MW-1:0]             nvmTurnOnDelay,
	input  wire logic [MW-1:0]             nvmRampTime,
	input  wire logic                      ssDetectEn,
	input  wire logic                      ssLoad,
	input  wire logic [MW-1:0]             ssMant,
	// Outputs.
	output logic [15:0]                    rdData,
	output stc_flag_s                      flags,
	output logic                           nvmStore,
	output logic [MW-1:0]                  nvmTurnOnDelayOut,
	output logic [MW-1:0]                  nvmRampTimeOut,
	output logic [MW-1:0]                  turnOnDelayMs,
	output logic                           turnOnDelayTiny,
	output logic [MW-1:0]                  rampTimeMs
);
	logic [MW-1:0]              turnOnDelay;
	logic [MW-1:0]              rampTime;
	logic [`STC_OTW_MANT_W-1:0] otWarn;
	logic [MW-1:0]              tonMs;
	logic                       tonTiny;
	logic [MW-1:0]              riseMs;
	logic [15:0]                next_rdData;

	// Decode of host writes.
	wire wrTon  = hostWr.valid && hostWr.cmd == `STC_CMD_TURN_ON_DELAY;
	wire wrRise = hostWr.valid && hostWr.cmd == `STC_CMD_RAMP_TIME;
	wire wrOtw  = hostWr.valid && hostWr.cmd == `STC_CMD_OT_WARN;
	wire [MW-1:0] wrMant = hostWr.data[`STC_MANT_LSB +: MW];
	wire [`STC_OTW_MANT_W-1:0] wrOtwMant =
		hostWr.data[`STC_MANT_LSB +: `STC_OTW_MANT_W];
	wire limitOn = rampTimeoutLimit != `STC_TMAX_DISABLED;
	wire riseBad = wrRise && limitOn && wrMant > rampTimeoutLimit;
	wire otwBad  = wrOtw && (wrOtwMant < `STC_OTW_MIN ||
		wrOtwMant > `STC_OTW_MAX ||
		wrOtwMant >= overtempFaultThreshold);
	wire reject  = riseBad || otwBad;

	// Read mux; exponents and upper mantissa bits read zero.
	always_comb begin
		next_rdData = 16'h0000;
		unique case (rdCmd)
			`STC_CMD_TURN_ON_DELAY: next_rdData = {`STC_EXP_ZERO,
				`STC_UPPER_ZERO, turnOnDelay};
			`STC_CMD_RAMP_TIME: next_rdData = {`STC_EXP_ZERO,
				`STC_UPPER_ZERO, rampTime};
			`STC_CMD_OT_WARN: next_rdData = {`STC_EXP_ZERO, otWarn};
			default: next_rdData = 16'h0000;
		endcase
	end

	// Turn-on delay register.
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			turnOnDelay <= `STC_TON_RESET;
		else if (nvmLoad)
			turnOnDelay <= nvmTurnOnDelay;
		else if (wrTon)
			turnOnDelay <= wrMant;
	end

	// Ramp time register; resistor detection overrides restored value.
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			rampTime <= `STC_RISE_RESET;
		else if (ssDetectEn && ssLoad)
			rampTime <= ssMant;
		else if (nvmLoad)
			rampTime <= nvmRampTime;
		else if (wrRise && !riseBad)
			rampTime <= wrMant;
	end

	// Warning threshold register.
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			otWarn <= `STC_OTW_RESET;
		else if (wrOtw && !otwBad)
			otWarn <= wrOtwMant;
	end

	// Sticky rejection flags; a reject raises all three.
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			flags <= '0;
		else if (reject)
			flags <= '{commFault: 1'b1, invalidData: 1'b1,
				alert: 1'b1};
	end

	// Store-all snapshot toward nonvolatile memory.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			nvmStore          <= 1'b0;
			nvmTurnOnDelayOut <= `STC_TON_RESET;
			nvmRampTimeOut    <= `STC_RISE_RESET;
		end else begin
			nvmStore <= storeAll;
			if (storeAll) begin
				nvmTurnOnDelayOut <= turnOnDelay;
				nvmRampTimeOut    <= rampTime;
			end
		end
	end

	// Bucket decoders for applied times.
	stc_bucket #(.MW(MW)) tonDec (
		.mant   (turnOnDelay),
		.minOne (1'b0),
		.effMs  (tonMs),
		.tiny   (tonTiny)
	);
	stc_bucket #(.MW(MW)) riseDec (
		.mant   (rampTime),
		.minOne (1'b1),
		.effMs  (riseMs),
		.tiny   ()
	);

	// Registered outputs.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdData          <= 16'h0000;
			turnOnDelayMs   <= `STC_MS_ZERO;
			turnOnDelayTiny <= 1'b1;
			rampTimeMs      <= `STC_RISE_RESET;
		end else begin
			rdData          <= next_rdData;
			turnOnDelayMs   <= tonMs;
			turnOnDelayTiny <= tonTiny;
			rampTimeMs      <= riseMs;
		end
	end
endmodule

/* File: stc_regs_props.sv */
// Concurrent checks on the ports of the startup timing register bank.
// Assumes stc_regs with one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module stc_regs_props
	import stc_pkg::*;
#(
	parameter int MW = 7
) (
	// Clock, reset and inputs.
	input wire logic          ref_clk, nrst, storeAll, nvmLoad,
	input wire logic          ssDetectEn, ssLoad,
	input wire stc_wr_s       hostWr,
	input wire logic [7:0]    rdCmd,
	input wire logic [MW-1:0] rampTimeoutLimit,
	// Outputs under watch.
	input wire logic [15:0]   rdData,
	input wire stc_flag_s     flags,
	input wire logic          nvmStore, turnOnDelayTiny,
	input wire logic [MW-1:0] turnOnDelayMs, rampTimeMs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// A ramp write that no load outranks in this cycle.
	wire rampWr = hostWr.valid && hostWr.cmd == 8'h61 && !nvmLoad
		&& !(ssLoad && ssDetectEn);
	a_rd_exp_zero: assert property ($past(rdCmd) inside {8'h60, 8'h61} |->
		rdData[15:7] == 9'h000) else $error("time word high bits set");
	a_otw_range: assert property ($past(rdCmd) == 8'h51 && $past(nrst) |->
		rdData inside {[16'h0064:16'h008C]}) else $error("warn out of range");
	a_store_pulse: assert property ($past(nrst) |->
		nvmStore == $past(storeAll)) else $error("store pulse wrong");
	a_ramp_reject: assert property (rampWr && rampTimeoutLimit != 0 &&
		hostWr.data[MW-1:0] > rampTimeoutLimit |=> flags == 3'h7)
		else $error("ramp reject not flagged");
	a_ramp_nocheck: assert property (rampWr && rampTimeoutLimit == 0 |=>
		$stable(flags)) else $error("flags moved with check off");
	a_tiny_zero: assert property (turnOnDelayTiny == (turnOnDelayMs == 0))
		else $error("tiny delay mismatch");
	a_delay_set: assert property (turnOnDelayMs inside
		{[0:7], 10, 14, 19, 27, 37, 52, 72, 100}) else $error("delay bucket");
	a_ramp_set: assert property (rampTimeMs inside
		{[1:7], 10, 14, 19, 27, 37, 52, 72, 100}) else $error("ramp bucket");
	// Main scenarios seen.
	c_store: cover property (storeAll);
	c_alert: cover property (flags.alert);
	c_nocheck: cover property (rampWr && rampTimeoutLimit == 0);
endmodule
bind stc_regs stc_regs_props #(.MW(MW)) chk_u (.*);

/* File: stc_host.sv */
// Host controller model issuing register writes to the bank.
// Assumes the bank samples hostWr on rising edges of ref_clk.
`timescale 1ns/1ps
module stc_host
	import stc_pkg::*;
(
	input  wire logic ref_clk,
	output stc_wr_s   hostWr
);
	initial hostWr = '0;
	// One write; released fields are inverted so stale data never looks valid.
	task automatic send(input logic [7:0] cmd, input logic [15:0] data);
		@(posedge ref_clk);
		hostWr <= '{1'b1, cmd, data};
		@(posedge ref_clk);
		hostWr <= '{1'b0, ~cmd, ~data};
	endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the startup timing register bank.
// Assumes stc_host for writes; an integer model predicts the bucket times.
`timescale 1ns/1ps
module testbench
	import stc_pkg::*;
;
	logic ref_clk = 0, nrst = 0, storeAll = 0, nvmLoad = 0;
	logic ssDetectEn = 0, ssLoad = 0;
	logic [7:0] rdCmd = 8'h60;
	logic [6:0] rampTimeoutLimit = '0, nvmTurnOnDelay = '0;
	logic [6:0] nvmRampTime = '0, ssMant = '0;
	logic [10:0] overtempFaultThreshold = 11'h096;
	stc_wr_s hostWr;
	stc_flag_s flags;
	logic [15:0] rdData;
	logic nvmStore, turnOnDelayTiny;
	logic [6:0] nvmTurnOnDelayOut, nvmRampTimeOut, turnOnDelayMs, rampTimeMs;
	int fail_count = 0, tests_run = 0, v;
	stc_host host_u (.ref_clk(ref_clk), .hostWr(hostWr));
	stc_regs dut_u (.*);
	// Free-running 250 MHz clock.
	initial forever #2 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Model of the supported times; r selects the ramp variant.
	function automatic int bk(input int m, input int r);
		int lim[8] = '{9, 12, 17, 22, 32, 44, 62, 86};
		int ms[8] = '{7, 10, 14, 19, 27, 37, 52, 72};
		if (r != 0 && m <= 1) return 1;
		if (m <= 6) return m;
		foreach (lim[i]) if (m <= lim[i]) return ms[i];
		return 100;
	endfunction
	task automatic rd(input logic [7:0] c, input int e);
		@(posedge ref_clk);
		rdCmd <= c;
		@(posedge ref_clk);
		#1 chk(rdData, e[15:0]);
	endtask
	// Hang guard.
	initial begin
		repeat (100000) @(posedge ref_clk);
		fail_count++;
		end_sim;
	end
	// Main sequence.
	initial begin
		v = $urandom(51660);
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h60, 0);
		rd(8'h61, 5);
		rd(8'h51, 100);
		for (int m = 0; m < 128; m++) begin
			v = $urandom;
			host_u.send(8'h60, {v[8:0], m[6:0]});
			rd(8'h60, m);
			chk(16'(turnOnDelayMs), 16'(bk(m, 0)));
			chk(16'(turnOnDelayTiny), 16'(m == 0));
			host_u.send(8'h61, {v[24:16], m[6:0]});
			rd(8'h61, m);
			chk(16'(rampTimeMs), 16'(bk(m, 1)));
		end
		chk(16'(flags), 16'h0);
		@(posedge ref_clk);
		rampTimeoutLimit <= 7'h0A;
		host_u.send(8'h61, 16'h000B);
		rd(8'h61, 127);
		chk(16'(flags), 16'h7);
		host_u.send(8'h61, 16'h000A);
		rd(8'h61, 10);
		host_u.send(8'h51, 16'h0078);
		rd(8'h51, 120);
		host_u.send(8'h51, 16'h008D);
		rd(8'h51, 120);
		host_u.send(8'h51, 16'h0063);
		rd(8'h51, 120);
		@(posedge ref_clk);
		overtempFaultThreshold <= 11'h07D;
		host_u.send(8'h51, 16'h007D);
		rd(8'h51, 120);
		host_u.send(8'h51, 16'h007C);
		rd(8'h51, 124);
		@(posedge ref_clk);
		storeAll <= 1'b1;
		@(posedge ref_clk);
		storeAll <= 1'b0;
		#1 chk(16'(nvmStore), 16'h1);
		@(posedge ref_clk);
		chk({nvmTurnOnDelayOut, 2'h0, nvmRampTimeOut}, 16'hFE0A);
		v = $urandom;
		@(posedge ref_clk);
		ssDetectEn <= 1'b1;
		ssMant <= v[6:0];
		nvmRampTime <= ~v[6:0];
		nvmTurnOnDelay <= v[13:7];
		{ssLoad, nvmLoad} <= 2'h3;
		@(posedge ref_clk);
		{ssLoad, nvmLoad} <= 2'h0;
		rd(8'h61, v[6:0]);
		rd(8'h60, v[13:7]);
		end_sim;
	end
endmodule
